// *** core/xinsn_exec.v ***
// execution unit for nibble swap, zero skips, table reads and xor
// Notes on behaviour
// [RQ1] swap memory nibbles into accumulator only
// [RQ2] skip next when memory byte zero
// [RQ3] skipping adds one dummy cycle
// [RQ4] copy byte to accumulator, skip if zero
// [RQ5] skip next when selected bit clear
// [RQ6] table read inside current page
// [RQ7] table read inside last page
// [RQ8] increment low pointer, read full pointer
// [RQ9] increment low pointer, read last page
// [RQ10] xor into accumulator, zero flag only
// [RQ11] xor into memory, zero flag only
// [RQ12] no skip completes in one cycle
`timescale 1ns/10ps
`include "xinsn_defines.vh"
module xinsn_exec #(
   parameter PADDR_W = 12            // program address width, 9 to 16
) (
   input  wire        sys_clk,       // system clock
   input  wire        rst_b,         // asynchronous reset, active low
   input  wire [7:0]  s_axi_awaddr,  // write address
   input  wire        s_axi_awvalid, // write address valid
   output reg         s_axi_awready, // write address ready
   input  wire [31:0] s_axi_wdata,   // write data
   input  wire [3:0]  s_axi_wstrb,   // write byte strobes
   input  wire        s_axi_wvalid,  // write data valid
   output reg         s_axi_wready,  // write data ready
   output reg  [1:0]  s_axi_bresp,   // write response
   output reg         s_axi_bvalid,  // write response valid
   input  wire        s_axi_bready,  // write response ready
   input  wire [7:0]  s_axi_araddr,  // read address
   input  wire        s_axi_arvalid, // read address valid
   output reg         s_axi_arready, // read address ready
   output reg  [31:0] s_axi_rdata,   // read data
   output reg  [1:0]  s_axi_rresp,   // read response
   output reg         s_axi_rvalid,  // read data valid
   input  wire        s_axi_rready   // read data ready
);
   localparam ST_IDLE  = 2'd0;
   localparam ST_EXEC  = 2'd1;
   localparam ST_DUMMY = 2'd2;
   localparam PDEPTH   = 1 << PADDR_W;

   reg [1:0]          rst_sync_reg;
   wire               rst_n_int = rst_sync_reg[1];

   reg [7:0]          dmem [0:255];
   reg [15:0]         pmem [0:PDEPTH-1];

   reg [1:0]          state_reg;
   reg [3:0]          op_reg;
   reg [2:0]          bit_reg;
   reg [7:0]          addr_reg;
   reg [7:0]          acc_reg;
   reg [7:0]          tbl_low_reg;
   reg [7:0]          tbl_high_reg;
   reg [7:0]          tbl_latch_reg;
   reg [PADDR_W-1:0]  pc_reg;
   reg                zero_reg;
   reg                skipped_reg;
   reg                bad_op_reg;
   reg [7:0]          dmem_index_reg;
   reg [PADDR_W-1:0]  pmem_index_reg;

   reg                aw_have_reg;
   reg                w_have_reg;
   reg [7:0]          awaddr_reg;
   reg [31:0]         wdata_reg;
   reg [3:0]          wstrb_reg;

   wire [7:0]         alu_result;
   wire               alu_write_acc;
   wire               alu_write_mem;
   wire               alu_write_latch;
   wire               alu_skip;
   wire               alu_set_zero;
   wire               alu_valid;

   wire [7:0]         mem_byte = dmem[addr_reg];
   wire               inc_first = (op_reg == `OP_INC_THEN_TABLE_READ) |
                                  (op_reg == `OP_INC_THEN_READ_LAST);
   wire [7:0]         tbl_low_eff = inc_first ? tbl_low_reg + 8'h01
                                              : tbl_low_reg;
   reg  [PADDR_W-1:0] table_addr;
   wire [15:0]        table_word = pmem[table_addr];
   wire               exec_now = (state_reg == ST_EXEC);

   wire               do_write = aw_have_reg & w_have_reg & ~s_axi_bvalid;
   wire               cmd_write = do_write & (awaddr_reg == `OFS_COMMAND) &
                                  wstrb_reg[0];
   wire               ar_take = s_axi_arvalid & s_axi_arready;

   always @* begin
      case (op_reg)
         // [RQ7] last page pointer
         `OP_TABLE_READ_LAST_PAGE, `OP_INC_THEN_READ_LAST:
            table_addr = {{(PADDR_W-8){1'b1}}, tbl_low_eff};
         // [RQ8] full high and low pointer
         `OP_INC_THEN_TABLE_READ:
            table_addr = {tbl_high_reg[PADDR_W-9:0], tbl_low_eff};
         // [RQ6] current page pointer
         default:
            table_addr = {pc_reg[PADDR_W-1:8], tbl_low_eff};
      endcase
   end

   insn_alu u_alu (
      .op          (op_reg),
      .bit_sel     (bit_reg),
      .acc         (acc_reg),
      .mem         (mem_byte),
      .table_low   (table_word[7:0]),
      .result      (alu_result),
      .write_acc   (alu_write_acc),
      .write_mem   (alu_write_mem),
      .write_latch (alu_write_latch),
      .skip        (alu_skip),
      .set_zero    (alu_set_zero),
      .valid_op    (alu_valid)
   );

   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_sync_reg <= 2'b00;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end

   // memories hold no reset; the executing instruction wins over the bus
   always @(posedge sys_clk) begin
      if (exec_now && alu_write_mem && alu_valid) begin
         dmem[addr_reg] <= alu_result;
      end else if (do_write && awaddr_reg == `OFS_DMEM_DATA &&
                   wstrb_reg[0]) begin
         dmem[dmem_index_reg] <= wdata_reg[7:0];
      end
      if (do_write && awaddr_reg == `OFS_PMEM_DATA) begin
         if (wstrb_reg[0]) begin
            pmem[pmem_index_reg][7:0] <= wdata_reg[7:0];
         end
         if (wstrb_reg[1]) begin
            pmem[pmem_index_reg][15:8] <= wdata_reg[15:8];
         end
      end
   end

   // execution state and core registers
   always @(posedge sys_clk or negedge rst_n_int) begin
      if (!rst_n_int) begin
         state_reg      <= ST_IDLE;
         op_reg         <= 4'h0;
         bit_reg        <= 3'h0;
         addr_reg       <= `RST_BYTE;
         acc_reg        <= `RST_BYTE;
         tbl_low_reg    <= `RST_BYTE;
         tbl_high_reg   <= `RST_BYTE;
         tbl_latch_reg  <= `RST_BYTE;
         pc_reg         <= {PADDR_W{1'b0}};
         zero_reg       <= 1'b0;
         skipped_reg    <= 1'b0;
         bad_op_reg     <= 1'b0;
         dmem_index_reg <= `RST_BYTE;
         pmem_index_reg <= {PADDR_W{1'b0}};
      end else begin
         if (do_write && wstrb_reg[0]) begin
            case (awaddr_reg)
               `OFS_ACCUMULATOR:  acc_reg <= wdata_reg[7:0];
               `OFS_TBL_LOW:      tbl_low_reg <= wdata_reg[7:0];
               `OFS_TBL_HIGH:     tbl_high_reg <= wdata_reg[7:0];
               `OFS_DMEM_INDEX:   dmem_index_reg <= wdata_reg[7:0];
               `OFS_PMEM_INDEX:   pmem_index_reg <= wdata_reg[PADDR_W-1:0];
               `OFS_PROG_COUNTER: pc_reg <= wdata_reg[PADDR_W-1:0];
               // write one to clear, a new fault in this cycle still sets
               `OFS_STATUS:
                  if (wdata_reg[`ST_BAD_OP]) bad_op_reg <= 1'b0;
               default: ;
            endcase
         end
         case (state_reg)
            ST_IDLE: begin
               // commands arriving while busy are dropped
               if (cmd_write) begin
                  op_reg    <= wdata_reg[`CMD_OP_MSB:`CMD_OP_LSB];
                  bit_reg   <= wdata_reg[`CMD_BIT_MSB:`CMD_BIT_LSB];
                  addr_reg  <= wdata_reg[`CMD_ADDR_MSB:`CMD_ADDR_LSB];
                  state_reg <= ST_EXEC;
               end
            end
            ST_EXEC: begin
               if (!alu_valid) begin
                  bad_op_reg  <= 1'b1;
                  skipped_reg <= 1'b0;
                  state_reg   <= ST_IDLE;
               end else begin
                  if (alu_write_acc) acc_reg <= alu_result;
                  if (alu_write_latch) tbl_latch_reg <= table_word[15:8];
                  // [RQ8] [RQ9] pointer advanced first
                  if (inc_first) tbl_low_reg <= tbl_low_eff;
                  if (alu_set_zero) zero_reg <= (alu_result == 8'h00);
                  skipped_reg <= alu_skip;
                  if (alu_skip) begin
                     // [RQ3] dummy cycle on skip
                     pc_reg    <= pc_reg + {{(PADDR_W-2){1'b0}}, 2'd2};
                     state_reg <= ST_DUMMY;
                  end else begin
                     // [RQ12] single cycle finish
                     pc_reg    <= pc_reg + {{(PADDR_W-1){1'b0}}, 1'b1};
                     state_reg <= ST_IDLE;
                  end
               end
            end
            ST_DUMMY: begin
               state_reg <= ST_IDLE;
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   function [31:0] read_mux;
      input [7:0] a;
      begin
         case (a)
            `OFS_COMMAND:      read_mux = {16'h0000, addr_reg, 1'b0,
                                           bit_reg, op_reg};
            `OFS_STATUS:       read_mux = {28'h0000000, bad_op_reg, zero_reg,
                                           skipped_reg,
                                           state_reg != ST_IDLE};
            `OFS_ACCUMULATOR:  read_mux = {24'h000000, acc_reg};
            `OFS_TBL_LOW:      read_mux = {24'h000000, tbl_low_reg};
            `OFS_TBL_HIGH:     read_mux = {24'h000000, tbl_high_reg};
            `OFS_TBL_LATCH:    read_mux = {24'h000000, tbl_latch_reg};
            `OFS_DMEM_INDEX:   read_mux = {24'h000000, dmem_index_reg};
            `OFS_DMEM_DATA:    read_mux = {24'h000000, dmem[dmem_index_reg]};
            `OFS_PMEM_INDEX:   read_mux = {{(32-PADDR_W){1'b0}},
                                           pmem_index_reg};
            `OFS_PMEM_DATA:    read_mux = {16'h0000, pmem[pmem_index_reg]};
            `OFS_PROG_COUNTER: read_mux = {{(32-PADDR_W){1'b0}}, pc_reg};
            default:           read_mux = 32'h00000000;
         endcase
      end
   endfunction

   function mapped;
      input [7:0] a;
      begin
         mapped = (a[1:0] == 2'b00) && (a <= `OFS_PROG_COUNTER);
      end
   endfunction

   // axi4-lite slave; one write and one read outstanding at a time
   always @(posedge sys_clk or negedge rst_n_int) begin
      if (!rst_n_int) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `RESP_OKAY;
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `RESP_OKAY;
         aw_have_reg   <= 1'b0;
         w_have_reg    <= 1'b0;
         awaddr_reg    <= 8'h00;
         wdata_reg     <= 32'h00000000;
         wstrb_reg     <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_reg   <= 1'b1;
            awaddr_reg    <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_reg   <= 1'b1;
            wdata_reg    <= s_axi_wdata;
            wstrb_reg    <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (do_write) begin
            aw_have_reg  <= 1'b0;
            w_have_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(awaddr_reg) ? `RESP_OKAY : `RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
         if (ar_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= read_mux(s_axi_araddr);
            s_axi_rresp   <= mapped(s_axi_araddr) ? `RESP_OKAY
                                                  : `RESP_SLVERR;
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end
endmodule

// *** core/xinsn_defines.vh ***
// constants for the extended skip, table and xor execution block
`ifndef XINSN_DEFINES_VH
`define XINSN_DEFINES_VH

// register byte offsets
`define OFS_COMMAND      8'h00
`define OFS_STATUS       8'h04
`define OFS_ACCUMULATOR  8'h08
`define OFS_TBL_LOW      8'h0C
`define OFS_TBL_HIGH     8'h10
`define OFS_TBL_LATCH    8'h14
`define OFS_DMEM_INDEX   8'h18
`define OFS_DMEM_DATA    8'h1C
`define OFS_PMEM_INDEX   8'h20
`define OFS_PMEM_DATA    8'h24
`define OFS_PROG_COUNTER 8'h28

// command field positions
`define CMD_OP_LSB       0
`define CMD_OP_MSB       3
`define CMD_BIT_LSB      4
`define CMD_BIT_MSB      6
`define CMD_ADDR_LSB     8
`define CMD_ADDR_MSB     15

// status field positions
`define ST_BUSY          0
`define ST_SKIPPED       1
`define ST_ZERO          2
`define ST_BAD_OP        3

// operation codes
`define OP_NIBBLE_SWAP_TO_ACC    4'h0
`define OP_SKIP_IF_ZERO          4'h1
`define OP_COPY_AND_SKIP_IF_ZERO 4'h2
`define OP_SKIP_IF_BIT_ZERO      4'h3
`define OP_TABLE_READ_CUR_PAGE   4'h4
`define OP_TABLE_READ_LAST_PAGE  4'h5
`define OP_INC_THEN_TABLE_READ   4'h6
`define OP_INC_THEN_READ_LAST    4'h7
`define OP_XOR_TO_ACC            4'h8
`define OP_XOR_TO_MEMORY         4'h9

// reset values
`define RST_BYTE         8'h00
`define RST_PC           16'h0000

// axi responses
`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10

`endif

// *** core/insn_alu.v ***
// combinational result, skip and flag logic for one instruction
`timescale 1ns/10ps
`include "xinsn_defines.vh"
module insn_alu (
   input  wire [3:0] op,          // operation code
   input  wire [2:0] bit_sel,     // bit index for the bit test
   input  wire [7:0] acc,         // current accumulator
   input  wire [7:0] mem,         // addressed data memory byte
   input  wire [7:0] table_low,   // low byte of the fetched table word
   output reg  [7:0] result,      // value to store
   output reg        write_acc,   // result goes to the accumulator
   output reg        write_mem,   // result goes to data memory
   output reg        write_latch, // table high byte goes to the latch
   output reg        skip,        // next instruction is skipped
   output reg        set_zero,    // zero flag is updated
   output reg        valid_op     // operation code is known
);
   always @* begin
      result      = 8'h00;
      write_acc   = 1'b0;
      write_mem   = 1'b0;
      write_latch = 1'b0;
      skip        = 1'b0;
      set_zero    = 1'b0;
      valid_op    = 1'b1;
      case (op)
         // [RQ1] swap nibbles into acc
         `OP_NIBBLE_SWAP_TO_ACC: begin
            result    = {mem[3:0], mem[7:4]};
            write_acc = 1'b1;
         end
         // [RQ2] skip on zero byte
         `OP_SKIP_IF_ZERO: begin
            skip = (mem == 8'h00);
         end
         // [RQ4] copy then skip
         `OP_COPY_AND_SKIP_IF_ZERO: begin
            result    = mem;
            write_acc = 1'b1;
            skip      = (mem == 8'h00);
         end
         // [RQ5] skip on clear bit
         `OP_SKIP_IF_BIT_ZERO: begin
            skip = ~mem[bit_sel];
         end
         `OP_TABLE_READ_CUR_PAGE, `OP_TABLE_READ_LAST_PAGE,
         `OP_INC_THEN_TABLE_READ, `OP_INC_THEN_READ_LAST: begin
            result      = table_low;
            write_mem   = 1'b1;
            write_latch = 1'b1;
         end
         // [RQ10] xor into acc
         `OP_XOR_TO_ACC: begin
            result    = acc ^ mem;
            write_acc = 1'b1;
            set_zero  = 1'b1;
         end
         // [RQ11] xor into memory
         `OP_XOR_TO_MEMORY: begin
            result    = acc ^ mem;
            write_mem = 1'b1;
            set_zero  = 1'b1;
         end
         default: begin
            valid_op = 1'b0;
         end
      endcase
   end
endmodule

// *** tb/xinsn_exec_sva.sv ***
// bus protocol checks on the execution unit's register port
`timescale 1ns/10ps
`include "xinsn_defines.vh"
module xinsn_exec_sva #(
   parameter PADDR_W = 12             // program address width
) (
   input logic        sys_clk,        // clock
   input logic        rst_b,          // reset, active low
   input logic [7:0]  s_axi_awaddr,   // aw
   input logic        s_axi_awvalid,  // aw
   input logic        s_axi_awready,  // aw
   input logic [31:0] s_axi_wdata,    // w
   input logic [3:0]  s_axi_wstrb,    // w
   input logic        s_axi_wvalid,   // w
   input logic        s_axi_wready,   // w
   input logic [1:0]  s_axi_bresp,    // b
   input logic        s_axi_bvalid,   // b
   input logic        s_axi_bready,   // b
   input logic [7:0]  s_axi_araddr,   // ar
   input logic        s_axi_arvalid,  // ar
   input logic        s_axi_arready,  // ar
   input logic [31:0] s_axi_rdata,    // r
   input logic [1:0]  s_axi_rresp,    // r
   input logic        s_axi_rvalid,   // r
   input logic        s_axi_rready    // r
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   sequence wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   a_b_after_take:
      assert property (wr_take |-> ##2 (s_axi_bvalid && !s_axi_awready))
      else $error("write response late");
   a_b_release:
      assert property (s_axi_bvalid && s_axi_bready |=>
         !s_axi_bvalid && s_axi_awready && s_axi_wready)
      else $error("write channel not released");
   a_r_after_take:
      assert property (rd_take |=> s_axi_rvalid && !s_axi_arready)
      else $error("read data late");
   a_r_release:
      assert property (s_axi_rvalid && s_axi_rready |=>
         !s_axi_rvalid && s_axi_arready)
      else $error("read channel not released");
   a_slverr_zero:
      assert property (s_axi_rvalid && s_axi_rresp == `RESP_SLVERR |->
         s_axi_rdata == 32'h0000_0000)
      else $error("error read returns data");
   a_bresp_legal:
      assert property (s_axi_bvalid |->
         s_axi_bresp == `RESP_OKAY || s_axi_bresp == `RESP_SLVERR)
      else $error("bad write response code");
   a_b_no_lone:
      assert property ($rose(s_axi_bvalid) |->
         !s_axi_awready && !s_axi_wready)
      else $error("write response without request");
   a_r_no_lone:
      assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid) &&
         $past(s_axi_arready))
      else $error("read data without request");
endmodule

// *** tb/tb_top.sv ***
// register-level bench for the skip, table and xor execution unit
`timescale 1ns/10ps
`include "xinsn_defines.vh"
`define CHK(g, e) begin checked = checked + 1; \
   if ((g) !== (e)) begin mismatches = mismatches + 1; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
   localparam PADDR_W = 10;
   logic sys_clk, rst_b;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, v;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready, z;
   logic [9:0] pc;
   logic [9:0] pa [0:3];
   logic [15:0] tw [0:3];
   integer mismatches, checked, i;
   xinsn_exec #(.PADDR_W(PADDR_W)) DUT (.*);
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   task results;
      if (mismatches == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task timeout;
      mismatches = mismatches + 1;
      results;
   endtask
   // bready and rready stay high, so every answer is taken at once
   task automatic wr(input [7:0] a, input [31:0] d);
      integer n;
      s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; n = 0;
      do begin
         @(posedge sys_clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         n = n + 1;
      end while (!s_axi_bvalid && n < 40);
      resp = s_axi_bresp;
      if (n >= 40) timeout;
   endtask
   task automatic rd(input [7:0] a, output [31:0] d);
      integer n;
      s_axi_araddr <= a; s_axi_arvalid <= 1'b1; n = 0;
      do begin
         @(posedge sys_clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         n = n + 1;
      end while (!s_axi_rvalid && n < 40);
      d = s_axi_rdata; resp = s_axi_rresp;
      if (n >= 40) timeout;
   endtask
   task automatic chkreg(input [7:0] a, input [31:0] e);
      rd(a, v);
      `CHK(v, e)
   endtask
   task automatic putm(input [7:0] a, input [7:0] d);
      wr(`OFS_DMEM_INDEX, {24'h0, a});
      wr(`OFS_DMEM_DATA, {24'h0, d});
   endtask
   task automatic chkm(input [7:0] a, input [7:0] e);
      wr(`OFS_DMEM_INDEX, {24'h0, a});
      chkreg(`OFS_DMEM_DATA, {24'h0, e});
   endtask
   // runs one instruction, then checks skip flag, zero flag and pc step
   task automatic ex(input [3:0] op, input [2:0] b, input [7:0] a,
                     input sk);
      integer n;
      wr(`OFS_COMMAND, {16'h0, a, 1'b0, b, op});
      // a skip is still in its dummy cycle at the first poll
      rd(`OFS_STATUS, v);
      `CHK(v[0], sk)
      n = 0;
      do begin
         rd(`OFS_STATUS, v);
         n = n + 1;
      end while (v[0] !== 1'b0 && n < 10);
      if (n >= 10) timeout;
      pc = pc + (sk ? 10'h2 : 10'h1);
      `CHK(v, {28'h0, 1'b0, z, sk, 1'b0})
      chkreg(`OFS_PROG_COUNTER, {22'h0, pc});
   endtask
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
      {s_axi_bready, s_axi_rready} = 2'h3;
      s_axi_awaddr = 8'h00; s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h0; s_axi_wstrb = 4'h0;
      rst_b = 1'b0; z = 1'b0; pc = 10'h000;
      mismatches = 0; checked = 0;
      pa[0] = 10'h134; pa[1] = 10'h334; pa[2] = 10'h235; pa[3] = 10'h336;
      tw[0] = 16'hA1B2; tw[1] = 16'hC3D4; tw[2] = 16'hE5F6; tw[3] = 16'h1728;
      repeat (16) @(posedge sys_clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge sys_clk);
      chkreg(`OFS_STATUS, 32'h0);
      putm(8'h10, 8'h3C);
      wr(`OFS_ACCUMULATOR, 32'h5A);
      ex(`OP_NIBBLE_SWAP_TO_ACC, 3'h0, 8'h10, 1'b0);
      chkreg(`OFS_ACCUMULATOR, 32'hC3);
      chkm(8'h10, 8'h3C);
      putm(8'h11, 8'h00);
      ex(`OP_SKIP_IF_ZERO, 3'h0, 8'h11, 1'b1);
      ex(`OP_SKIP_IF_ZERO, 3'h0, 8'h10, 1'b0);
      ex(`OP_COPY_AND_SKIP_IF_ZERO, 3'h0, 8'h11, 1'b1);
      chkreg(`OFS_ACCUMULATOR, 32'h0);
      ex(`OP_COPY_AND_SKIP_IF_ZERO, 3'h0, 8'h10, 1'b0);
      chkreg(`OFS_ACCUMULATOR, 32'h3C);
      putm(8'h12, 8'h7E);
      for (i = 0; i < 8; i = i + 1)
         ex(`OP_SKIP_IF_BIT_ZERO, i[2:0], 8'h12, i == 0 || i == 7);
      for (i = 0; i < 4; i = i + 1) begin
         wr(`OFS_PMEM_INDEX, {22'h0, pa[i]});
         wr(`OFS_PMEM_DATA, {16'h0, tw[i]});
      end
      wr(`OFS_PROG_COUNTER, 32'h105);
      pc = 10'h105;
      wr(`OFS_TBL_LOW, 32'h34);
      wr(`OFS_TBL_HIGH, 32'h02);
      for (i = 0; i < 4; i = i + 1) begin
         ex(`OP_TABLE_READ_CUR_PAGE + i[3:0], 3'h0, 8'h20 + i[7:0],
            1'b0);
         chkm(8'h20 + i[7:0], tw[i][7:0]);
         chkreg(`OFS_TBL_LATCH,
                {24'h0, tw[i][15:8]});
      end
      chkreg(`OFS_TBL_LOW, 32'h36);
      wr(`OFS_ACCUMULATOR, 32'h5A);
      putm(8'h30, 8'h5A);
      z = 1'b1;
      ex(`OP_XOR_TO_ACC, 3'h0, 8'h30, 1'b0);
      chkreg(`OFS_ACCUMULATOR, 32'h0);
      chkm(8'h30, 8'h5A);
      putm(8'h31, 8'h0F);
      z = 1'b0;
      ex(`OP_XOR_TO_ACC, 3'h0, 8'h31, 1'b0);
      chkreg(`OFS_ACCUMULATOR, 32'h0F);
      z = 1'b1;
      ex(`OP_XOR_TO_MEMORY, 3'h0, 8'h31, 1'b0);
      chkm(8'h31, 8'h00);
      chkreg(`OFS_ACCUMULATOR, 32'h0F);
      rd(8'hF0, v);
      `CHK({v, resp}, {32'h0, `RESP_SLVERR})
      wr(8'hF0, 32'h1);
      `CHK(resp, `RESP_SLVERR)
      wr(`OFS_COMMAND, 32'hF);
      chkreg(`OFS_PROG_COUNTER, {22'h0, pc});
      rd(`OFS_STATUS, v);
      `CHK(v[3], 1'b1)
      wr(`OFS_STATUS, 32'h8);
      rd(`OFS_STATUS, v);
      `CHK(v[3], 1'b0)
      results;
   end
endmodule

bind xinsn_exec xinsn_exec_sva #(.PADDR_W(PADDR_W)) chk (.*);
